/* verification/laser_remote_hardwire_port_tb.sv */
module laser_remote_hardwire_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic req;
      logic sw;
      logic guide;
      logic analog;
      logic warn;
      logic [6:0] sel;
      logic [12:0] exp;
   } lhp_row_t;
   // Short clear window keeps the run brief
   localparam int CLR = 8;
   logic core_clk_in, reset_in;
   logic req, run, sw, clr, guide, analog, abort, sync, power;
   logic fault_c, warn_c, emit, sdone, swait, ssync, last;
   logic [6:0] sel, prog_num;
   logic [12:0] status;
   logic sp_analog, host_ctl, alarm_st, clr_busy;
   int error_cnt = 0;
   int compares = 0;
   int tick = 0;
   lhp_row_t rows [4] = '{
      '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 7'h00, 13'h0000},
      '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 7'h00, 13'h0441},
      '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 7'h00, 13'h01C0},
      '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 7'h40, 13'h0040}};
   lhp_if port_if ();
   lhp_device #(.CLR_CYC(CLR)) u_lhp_device (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .port_if(port_if), .fault_cond_in(fault_c),
      .warning_cond_in(warn_c), .emit_req_in(emit),
      .step_done_in(sdone), .step_wait_in(swait),
      .step_sync_in(ssync), .prog_last_in(last),
      .program_number_out(prog_num), .setpoint_analog_out(sp_analog),
      .host_control_out(host_ctl), .alarm_out(alarm_st));
   lhp_host #(.CLR_CYC(CLR)) u_lhp_host (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .port_if(port_if), .request_in(req), .run_in(run),
      .select_in(sel), .sw_enable_in(sw), .clear_pulse_in(clr),
      .guide_in(guide), .analog_in(analog), .abort_in(abort),
      .sync_in(sync), .power_in(power), .clear_busy_out(clr_busy),
      .status_out(status));
   lhp_port_chk u_lhp_port_chk (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .remote_request(port_if.remote_request),
      .software_enable(port_if.software_enable),
      .alarm_clear(port_if.alarm_clear),
      .guide_light(port_if.guide_light),
      .program_abort(port_if.program_abort),
      .program_run(port_if.program_run),
      .program_select(port_if.program_select),
      .main_power_request(port_if.main_power_request),
      .internal_mode(port_if.internal_mode),
      .guide_light_st(port_if.guide_light_st),
      .analog_mode(port_if.analog_mode),
      .request_ack(port_if.request_ack),
      .main_power(port_if.main_power),
      .program_running(port_if.program_running),
      .program_done(port_if.program_done),
      .abnormal_end(port_if.abnormal_end));
   initial begin
      core_clk_in = 1'h0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   task automatic complete_run();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge core_clk_in) begin
      tick <= tick + 1;
      if (tick == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [12:0] e,
         input logic [12:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Latencies are left to the design, so wait bounded
   task automatic await(input string nm, input int b, input logic v);
      int i;
      i = 0;
      while (status[b] !== v && i < 40) begin
         @(posedge core_clk_in);
         #1;
         i++;
      end
      chk(nm, {12'h000, v}, {12'h000, status[b]});
   endtask
   task automatic pulse_clear();
      @(posedge core_clk_in);
      clr <= 1'h1;
      @(posedge core_clk_in);
      clr <= 1'h0;
   endtask
   initial begin
      {req, run, sw, clr, guide, analog, abort, sync, power} <= '0;
      {fault_c, warn_c, emit, sdone, swait, ssync, last} <= '0;
      sel <= 7'h00;
      reset_in <= 1'h1;
      repeat (10) @(posedge core_clk_in);
      reset_in <= 1'h0;
      foreach (rows[i]) begin
         @(posedge core_clk_in);
         req <= rows[i].req;
         sw <= rows[i].sw;
         guide <= rows[i].guide;
         analog <= rows[i].analog;
         warn_c <= rows[i].warn;
         sel <= rows[i].sel;
         repeat (12) @(posedge core_clk_in);
         #1;
         chk("status", rows[i].exp, status);
         chk("setpoint", {11'h000, rows[i].exp[10],
            rows[i].exp[7]}, {11'h000, host_ctl, sp_analog});
      end
      @(posedge core_clk_in);
      power <= 1'h1;
      emit <= 1'h1;
      await("main power", 5, 1'h1);
      await("ready", 12, 1'h1);
      await("emission", 11, 1'h1);
      @(posedge core_clk_in);
      sel <= 7'h05;
      repeat (5) @(posedge core_clk_in);
      run <= 1'h1;
      await("running", 4, 1'h1);
      chk("program number", 13'h0005, {6'h00, prog_num});
      @(posedge core_clk_in);
      ssync <= 1'h1;
      swait <= 1'h1;
      await("sync out", 1, 1'h1);
      repeat (10) @(posedge core_clk_in);
      #1;
      chk("wait hold", 13'h0002, {11'h000, status[4:3]});
      @(posedge core_clk_in);
      {sync, sdone, last, swait} <= 4'hE;
      await("done", 3, 1'h1);
      chk("running end", 13'h0000, {12'h000, status[4]});
      @(posedge core_clk_in);
      {sync, sdone, last, run, ssync} <= '0;
      await("done clear", 3, 1'h0);
      @(posedge core_clk_in);
      sel <= 7'h02;
      repeat (5) @(posedge core_clk_in);
      run <= 1'h1;
      await("running", 4, 1'h1);
      @(posedge core_clk_in);
      run <= 1'h0;
      await("run stop", 4, 1'h0);
      chk("stop flags", 13'h0000, {11'h000, status[3:2]});
      @(posedge core_clk_in);
      run <= 1'h1;
      await("running", 4, 1'h1);
      @(posedge core_clk_in);
      abort <= 1'h1;
      await("aborted", 4, 1'h0);
      await("abnormal end", 2, 1'h1);
      @(posedge core_clk_in);
      {abort, run} <= '0;
      repeat (12) @(posedge core_clk_in);
      #1;
      chk("abnormal held", 13'h0001, {12'h000, status[2]});
      pulse_clear();
      await("abnormal clear", 2, 1'h0);
      @(posedge core_clk_in);
      fault_c <= 1'h1;
      @(posedge core_clk_in);
      fault_c <= 1'h0;
      await("fault", 9, 1'h1);
      await("ready drop", 12, 1'h0);
      repeat (12) @(posedge core_clk_in);
      #1;
      chk("fault held", 13'h0001, {12'h000, status[9]});
      chk("alarm latch", 13'h0001, {12'h000, alarm_st});
      pulse_clear();
      #1;
      chk("clear busy", 13'h0001, {12'h000, clr_busy});
      await("fault clear", 9, 1'h0);
      @(posedge core_clk_in);
      power <= 1'h0;
      await("power off", 5, 1'h0);
      @(posedge core_clk_in);
      req <= 1'h0;
      await("ack drop", 6, 1'h0);
      @(posedge core_clk_in);
      req <= 1'h1;
      reset_in <= 1'h1;
      repeat (10) @(posedge core_clk_in);
      #1;
      chk("reset status", 13'h0000, status);
      @(posedge core_clk_in);
      reset_in <= 1'h0;
      await("ack again", 6, 1'h1);
      complete_run();
   end
endmodule

/* verification/lhp_port_sva.sv */
module lhp_port_chk (
   input wire logic core_clk_in, // Clock
   input wire logic reset_in, // Reset
   input wire logic remote_request, // In
   input wire logic software_enable, // In
   input wire logic alarm_clear, // In
   input wire logic guide_light, // In
   input wire logic program_abort, // In
   input wire logic program_run, // In
   input wire logic [lhp_pkg::SEL_W-1:0] program_select, // In
   input wire logic main_power_request, // In
   input wire logic internal_mode, // Out
   input wire logic guide_light_st, // Out
   input wire logic analog_mode, // Out
   input wire logic request_ack, // Out
   input wire logic main_power, // Out
   input wire logic program_running, // Out
   input wire logic program_done, // Out
   input wire logic abnormal_end // Out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   a_ack_follows: assert property (
      $rose(remote_request) ##1 remote_request[*2] |=> request_ack)
      else $error("ack not raised");
   a_ack_drops: assert property (
      (!remote_request)[*5] |=> !request_ack)
      else $error("ack without request");
   a_power_gated: assert property (
      $rose(main_power) |-> $past(remote_request, 3))
      else $error("power without request");
   a_power_on: assert property (
      $rose(main_power_request) && remote_request ##1
      (remote_request && main_power_request)[*4] |-> main_power)
      else $error("power not on");
   a_guide_on: assert property (
      (remote_request && guide_light)[*6] |-> guide_light_st)
      else $error("guide status low");
   a_mode_follows: assert property (
      (remote_request && software_enable)[*6] |-> internal_mode)
      else $error("internal mode low");
   a_analog_zero: assert property (
      (remote_request && program_select != lhp_pkg::SEL_NONE)[*6]
      |-> !analog_mode)
      else $error("analog mode with program");
   a_done_clears: assert property (
      (remote_request && !program_run)[*6] |-> !program_done)
      else $error("done not cleared");
   a_abort_stops: assert property (
      program_running && program_abort && remote_request
      |-> ##[1:6] !program_running)
      else $error("abort ignored");
   a_abend_holds: assert property (
      (abnormal_end && !alarm_clear)[*6] |=> abnormal_end)
      else $error("abnormal end lost");
   cover property ($rose(request_ack));
   cover property ($rose(program_done));
   cover property ($rose(abnormal_end));
endmodule

/* verilog/lhp_device.sv */
module lhp_device #(
   parameter int CLR_CYC = lhp_pkg::CLR_MIN_CYC
) (
   input wire logic core_clk_in, // System clock
   input wire logic reset_in, // Sync reset, high
   lhp_if.device port_if, // Hardwired port
   input wire logic fault_cond_in, // Internal abnormal condition
   input wire logic warning_cond_in, // Internal warning condition
   input wire logic emit_req_in, // Emission wanted by program/host
   input wire logic step_done_in, // Current program step finished
   input wire logic step_wait_in, // Current step waits for sync
   input wire logic step_sync_in, // Sync level the step drives
   input wire logic prog_last_in, // Current step is the last
   output logic [lhp_pkg::SEL_W-1:0] program_number_out, // Selected
   output logic setpoint_analog_out, // Use analog setpoint
   output logic host_control_out, // Host PC control permitted
   output logic alarm_out // Latched alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NIN = 9;
   localparam int CW = $clog2(CLR_CYC + 1);
   localparam logic [CW-1:0] CLR_LIM = CW'(CLR_CYC);

   logic [NIN-1:0] raw;
   logic [NIN-1:0] lvl;
   logic [NIN-1:0] rise;
   logic [NIN-1:0] fall;
   logic [lhp_pkg::SEL_W-1:0] sel_q;
   logic req;

   assign raw = {port_if.remote_request, port_if.program_run,
      port_if.software_enable, port_if.alarm_clear, port_if.guide_light,
      port_if.analog_enable, port_if.program_abort, port_if.ext_sync,
      port_if.main_power_request};

   lhp_sync #(.W(NIN)) u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .d_in(raw),
      .q_out(lvl),
      .rise_out(rise),
      .fall_out(fall)
   );

   lhp_sync #(.W(lhp_pkg::SEL_W)) u_sel (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .d_in(port_if.program_select),
      .q_out(sel_q),
      .rise_out(),
      .fall_out()
   );

   assign req = lvl[8];
   wire run_l = lvl[7] & req;
   wire run_r = rise[7] & req;
   wire run_f = fall[7];
   wire sw_en = lvl[6] & req;
   wire clr_l = lvl[5] & req;
   wire guide = lvl[4] & req;
   wire ana_en = lvl[3] & req;
   wire abort = lvl[2] & req;
   wire sync_l = lvl[1] & req;
   wire pwr_r = rise[0] & req;
   wire pwr_f = fall[0] & req;

   lhp_pkg::lhp_prog_t st, next_st;
   logic [lhp_pkg::SEL_W-1:0] prog_num, next_prog_num;
   logic [CW-1:0] clr_cnt, next_clr_cnt;
   logic clr_armed, next_clr_armed;
   logic alarm, next_alarm;
   logic abn, next_abn;
   logic pwr, next_pwr;
   logic ack, next_ack;
   logic ana, next_ana;
   logic host, next_host;
   logic ready, next_ready;
   logic emis, next_emis;
   logic gl, next_gl;
   logic flt, next_flt;
   logic wrn, next_wrn;
   logic running, next_running;
   logic done, next_done;
   logic psync, next_psync;
   logic clear_fire;

   always_comb begin
      next_clr_cnt = clr_cnt;
      next_clr_armed = clr_armed;
      clear_fire = 1'b0;
      // Clear counts from its rising edge; fires once CLR_CYC cycles are reached (1 ms by default)
      if (!clr_l) begin
         next_clr_cnt = '0;
         next_clr_armed = 1'b0;
      end else if (rise[5] && req) begin
         next_clr_cnt = CW'(1);
         next_clr_armed = 1'b1;
      end else if (clr_armed) begin
         if (clr_cnt >= CLR_LIM - CW'(1)) begin
            clear_fire = 1'b1;
            next_clr_armed = 1'b0;
         end else begin
            next_clr_cnt = clr_cnt + CW'(1);
         end
      end
   end

   always_comb begin
      next_st = st;
      next_prog_num = prog_num;
      next_abn = abn;
      next_done = done;
      next_alarm = alarm;
      next_psync = 1'b0;
      // Clears first so a same-cycle event still sets
      if (clear_fire) begin
         next_alarm = 1'b0;
         next_abn = 1'b0;
      end
      if (fault_cond_in) begin
         next_alarm = 1'b1;
      end
      if (!run_l) begin
         next_done = 1'b0;
      end
      case (st)
         lhp_pkg::LHP_IDLE: begin
            if (run_r) begin
               next_prog_num = sel_q;
               next_done = 1'b0;
               if (sel_q != lhp_pkg::SEL_NONE) begin
                  next_st = lhp_pkg::LHP_RUN;
               end
            end
         end
         lhp_pkg::LHP_RUN, lhp_pkg::LHP_WAIT: begin
            next_psync = step_sync_in;
            if (abort || alarm || !req) begin
               next_st = lhp_pkg::LHP_IDLE;
               next_abn = 1'b1;
            end else if (run_f || !run_l) begin
               next_st = lhp_pkg::LHP_IDLE;
            end else if (st == lhp_pkg::LHP_WAIT) begin
               if (sync_l) begin
                  next_st = lhp_pkg::LHP_RUN;
               end
            end else if (step_wait_in) begin
               next_st = lhp_pkg::LHP_WAIT;
            end else if (step_done_in && prog_last_in) begin
               next_st = lhp_pkg::LHP_DONE;
               next_done = 1'b1;
            end
         end
         lhp_pkg::LHP_DONE: begin
            if (!run_l) begin
               next_st = lhp_pkg::LHP_IDLE;
            end
         end
         default: next_st = lhp_pkg::LHP_IDLE;
      endcase
   end

   always_comb begin
      next_pwr = pwr;
      if (pwr_r) begin
         next_pwr = 1'b1;
      end else if (pwr_f) begin
         next_pwr = 1'b0;
      end
      next_ack = req;
      // Analog only in non-programming mode; host control does not gate analog
      next_ana = req && (sel_q == lhp_pkg::SEL_NONE) && ana_en
         && (st == lhp_pkg::LHP_IDLE);
      next_host = sw_en;
      next_ready = pwr && !alarm;
      next_emis = pwr && !alarm && emit_req_in;
      next_gl = guide;
      next_flt = alarm;
      next_wrn = warning_cond_in;
      next_running = (next_st == lhp_pkg::LHP_RUN)
         || (next_st == lhp_pkg::LHP_WAIT);
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st <= lhp_pkg::LHP_IDLE;
         prog_num <= '0;
         clr_cnt <= '0;
         clr_armed <= 1'b0;
         alarm <= 1'b0;
         abn <= 1'b0;
         pwr <= 1'b0;
         ack <= 1'b0;
         ana <= 1'b0;
         host <= 1'b0;
         ready <= 1'b0;
         emis <= 1'b0;
         gl <= 1'b0;
         flt <= 1'b0;
         wrn <= 1'b0;
         running <= 1'b0;
         done <= 1'b0;
         psync <= 1'b0;
      end else begin
         st <= next_st;
         prog_num <= next_prog_num;
         clr_cnt <= next_clr_cnt;
         clr_armed <= next_clr_armed;
         alarm <= next_alarm;
         abn <= next_abn;
         pwr <= next_pwr;
         ack <= next_ack;
         ana <= next_ana;
         host <= next_host;
         ready <= next_ready;
         emis <= next_emis;
         gl <= next_gl;
         flt <= next_flt;
         wrn <= next_wrn;
         running <= next_running;
         done <= next_done;
         psync <= next_psync;
      end
   end

   assign port_if.request_ack = ack;
   assign port_if.main_power = pwr;
   assign port_if.ready = ready;
   assign port_if.emission = emis;
   assign port_if.internal_mode = host;
   assign port_if.fault = flt;
   assign port_if.warning = wrn;
   assign port_if.guide_light_st = gl;
   assign port_if.analog_mode = ana;
   assign port_if.program_running = running;
   assign port_if.program_done = done;
   assign port_if.abnormal_end = abn;
   assign port_if.program_sync = psync;
   assign program_number_out = prog_num;
   assign setpoint_analog_out = ana;
   assign host_control_out = host;
   assign alarm_out = alarm;
endmodule

/* verilog/lhp_host.sv */
module lhp_host #(
   parameter int CLR_CYC = lhp_pkg::CLR_MIN_CYC
) (
   input wire logic core_clk_in, // System clock
   input wire logic reset_in, // Sync reset, high
   lhp_if.host port_if, // Hardwired port
   input wire logic request_in, // Hold remote request
   input wire logic run_in, // Program run level
   input wire logic [lhp_pkg::SEL_W-1:0] select_in, // Program number
   input wire logic sw_enable_in, // Permit host PC control
   input wire logic clear_pulse_in, // One-cycle alarm clear request
   input wire logic guide_in, // Guide light wanted
   input wire logic analog_in, // Analog setpoint wanted
   input wire logic abort_in, // Abort program
   input wire logic sync_in, // External sync
   input wire logic power_in, // Main power wanted
   output logic clear_busy_out, // Alarm clear pulse in progress
   output logic [12:0] status_out // Sampled status outputs
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CW = $clog2(CLR_CYC + 1);
   localparam logic [CW-1:0] CLR_LIM = CW'(CLR_CYC);

   logic [CW-1:0] cnt, next_cnt;
   logic [lhp_pkg::SEL_W-1:0] sel, next_sel;
   logic [12:0] stat, next_stat;
   logic [8:0] drv, next_drv;

   always_comb begin
      next_cnt = cnt;
      // Clear held high for the full minimum, counted here
      if (cnt != '0) begin
         next_cnt = (cnt >= CLR_LIM) ? '0 : cnt + CW'(1);
      end else if (clear_pulse_in) begin
         next_cnt = CW'(1);
      end
      // Selection only changes while no run level is held
      next_sel = (run_in && drv[7]) ? sel : select_in;
      next_drv = {request_in, run_in, sw_enable_in, (next_cnt != '0), guide_in,
         analog_in && (select_in == lhp_pkg::SEL_NONE),
         abort_in, sync_in, power_in};
      next_stat = {port_if.ready, port_if.emission, port_if.internal_mode,
         port_if.fault, port_if.guide_light_st, port_if.analog_mode,
         port_if.request_ack, port_if.main_power, port_if.program_running,
         port_if.program_done, port_if.abnormal_end, port_if.program_sync,
         port_if.warning};
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cnt <= '0;
         sel <= '0;
         drv <= '0;
         stat <= '0;
      end else begin
         cnt <= next_cnt;
         sel <= next_sel;
         drv <= next_drv;
         stat <= next_stat;
      end
   end

   assign port_if.remote_request = drv[8];
   assign port_if.program_run = drv[7];
   assign port_if.software_enable = drv[6];
   assign port_if.alarm_clear = drv[5];
   assign port_if.guide_light = drv[4];
   assign port_if.analog_enable = drv[3];
   assign port_if.program_abort = drv[2];
   assign port_if.ext_sync = drv[1];
   assign port_if.main_power_request = drv[0];
   assign port_if.program_select = sel;
   assign clear_busy_out = drv[5];
   assign status_out = stat;
endmodule

/* verilog/lhp_if.sv */
interface lhp_if;
   timeunit 1ns;
   timeprecision 1ps;
   logic remote_request;
   logic program_run;
   logic software_enable;
   logic alarm_clear;
   logic guide_light;
   logic analog_enable;
   logic program_abort;
   logic [lhp_pkg::SEL_W-1:0] program_select;
   logic ext_sync;
   logic main_power_request;
   logic ready;
   logic emission;
   logic internal_mode;
   logic fault;
   logic guide_light_st;
   logic analog_mode;
   logic request_ack;
   logic main_power;
   logic program_running;
   logic program_done;
   logic abnormal_end;
   logic program_sync;
   logic warning;
   modport device (
      input remote_request, program_run, software_enable, alarm_clear,
      input guide_light, analog_enable, program_abort, program_select,
      input ext_sync, main_power_request,
      output ready, emission, internal_mode, fault, guide_light_st,
      output analog_mode, request_ack, main_power, program_running,
      output program_done, abnormal_end, program_sync, warning
   );
   modport host (
      output remote_request, program_run, software_enable, alarm_clear,
      output guide_light, analog_enable, program_abort, program_select,
      output ext_sync, main_power_request,
      input ready, emission, internal_mode, fault, guide_light_st,
      input analog_mode, request_ack, main_power, program_running,
      input program_done, abnormal_end, program_sync, warning
   );
endinterface

/* verilog/lhp_pkg.sv */
package lhp_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CLK_HZ = 125_000_000;
   localparam int SEL_W = 7;
   localparam int SYNC_STAGES = 2;
   // Least alarm clear high time, in microseconds
   localparam int CLR_MIN_US = 1000;
   localparam int CLR_MIN_CYC = (CLR_MIN_US * (CLK_HZ / 1_000_000));
   localparam logic [SEL_W-1:0] SEL_NONE = 7'h00;
   typedef enum logic [1:0] {
      LHP_IDLE,
      LHP_RUN,
      LHP_WAIT,
      LHP_DONE
   } lhp_prog_t;
endpackage

/* verilog/lhp_sync.sv */
module lhp_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_in, // System clock
   input wire logic reset_in, // Sync reset, high
   input wire logic [W-1:0] d_in, // Asynchronous levels
   output logic [W-1:0] q_out, // Synchronised levels
   output logic [W-1:0] rise_out, // One-cycle rising pulse
   output logic [W-1:0] fall_out // One-cycle falling pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] meta;
   logic [W-1:0] stage;
   logic [W-1:0] last;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_stage;
   logic [W-1:0] next_last;

   always_comb begin
      next_meta = d_in;
      next_stage = meta;
      next_last = stage;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         meta <= '0;
         stage <= '0;
         last <= '0;
      end else begin
         meta <= next_meta;
         stage <= next_stage;
         last <= next_last;
      end
   end

   assign q_out = stage;
   // Edges from the second stage only, one pulse per transition
   assign rise_out = stage & ~last;
   assign fall_out = ~stage & last;
endmodule
